// File: core/counter_control_and_readout.sv
// Purpose : executes the counter control command and counter read command
// Assumes : all command and status inputs come from logic on mclk_i
// Notes   : counting and pulse generation live elsewhere; this block holds
//           loaded present values, comparison enables and the error flag
// Notes on behaviour
// R1 - port selector 0, 1, 2 picks counter or pulse port 0, 1, 2
// R2 - control code 0 starts range comparison on the selected counter
// R3 - control code 1 stops range comparison on the selected counter
// R4 - control code 2 loads eight digits, low word right digits, next word left
// R5 - control code 3 stops pulse output on the selected port
// R6 - a command with its execution condition false does nothing at all
// R7 - the program passes zero as value unless control code is 2
// R8 - counter 0 value limits: up/down F0032767..00032767, incrementing 0..00065535
// R9 - top digit F means negative, other digits give magnitude
// R10 - counters 1 and 2: linear F8388607..08388607, ring 0..00064999
// R11 - absolute counters 1 and 2 refuse a present value load
// R12 - incompatible port and function or invalid operand sets the error flag
// R13 - control command from interrupt during main counter command sets error
// R14 - read code 0 returns eight digit value, lower word first
// R15 - absolute counters read 0..4095 or 0..0359, upper word zero
// R16 - status bit 0 comparing, bit 1 underflow or overflow seen
// R17 - status bits 4 decel, 5 total count, 6 done, 7 outputting
// R18 - undefined status bits read as zero
// R19 - absolute counters report only status bit 0, others zero
// R20 - read code 2 returns bits 0..7 in range flags for ranges 1..8
// R21 - status and range results are live, not once-per-scan copies
// R22 - a second word beyond the data area end sets the error flag
// R23 - each range flag is set while value lies inside its range; the code sets it only while comparison runs
// R24 - unlisted selector or code sets error and changes nothing
`default_nettype none
module counter_control_and_readout
    import counter_control_pkg::*;
#(
    parameter int unsigned NUM_CTR    = 3,
    parameter int unsigned NUM_RANGES = 8
)(
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    // control command
    input  wire logic        ctl_req_i,
    input  wire logic        ctl_cond_i,
    input  wire logic [1:0]  ctl_port_i,
    input  wire logic [1:0]  ctl_code_i,
    input  wire logic [15:0] value_source_words_lo_i,
    input  wire logic [15:0] value_source_words_hi_i,
    input  wire logic        ctl_past_end_i,
    input  wire logic        ctl_bad_operand_i,
    input  wire logic        in_interrupt_i,
    input  wire logic        main_busy_i,
    // read command
    input  wire logic        rd_req_i,
    input  wire logic        rd_cond_i,
    input  wire logic [1:0]  rd_port_i,
    input  wire logic [1:0]  rd_code_i,
    input  wire logic        rd_past_end_i,
    input  wire logic        rd_bad_operand_i,
    // counter configuration and live state from the counting logic
    input  wire logic        ctr0_updown_i,
    input  wire logic [1:0]  ctr12_ring_i,
    input  wire logic [1:0]  ctr12_absolute_i,
    input  wire logic [1:0]  ctr12_degree_i,
    input  wire logic [1:0][15:0] abs_pv_i,
    input  wire logic [NUM_CTR-1:0] ovf_seen_i,
    input  wire logic [NUM_CTR-1:0] decel_spec_i,
    input  wire logic [NUM_CTR-1:0] total_spec_i,
    input  wire logic [NUM_CTR-1:0] pulse_done_i,
    input  wire logic [NUM_CTR-1:0] pulse_active_i,
    input  wire logic [NUM_CTR-1:0][NUM_RANGES-1:0][31:0] range_lo_i,
    input  wire logic [NUM_CTR-1:0][NUM_RANGES-1:0][31:0] range_hi_i,
    // results
    output logic [NUM_CTR-1:0][31:0] present_value_o,
    output logic [NUM_CTR-1:0]       cmp_running_o,
    output logic [NUM_CTR-1:0][NUM_RANGES-1:0] in_range_o,
    output logic [NUM_CTR-1:0]       pulse_stop_o,
    output logic                     error_flag_o,
    output logic                     rd_valid_o,
    output logic [15:0]              rd_word_lo_o,
    output logic [15:0]              rd_word_hi_o
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers for signed bcd values

    // every digit decimal, except the top one which may be the sign digit
    function automatic logic is_bcd(input logic [31:0] v);
        logic ok;
        ok = (v[31:28] <= 4'h9) || (v[31:28] == NEG_DIGIT); // R9
        for (int i = 0; i < 7; i++)
        begin
            if (v[i*4 +: 4] > 4'h9)
            begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction : is_bcd

    // signed compare a <= b; bcd digit order matches hex order of magnitude
    function automatic logic bcd_le(input logic [31:0] a, input logic [31:0] b);
        logic an;
        logic bn;
        an = (a[31:28] == NEG_DIGIT); // R9
        bn = (b[31:28] == NEG_DIGIT);
        if (an != bn)
        begin
            return an;
        end
        if (an)
        begin
            return a[27:0] >= b[27:0];
        end
        return a[27:0] <= b[27:0];
    endfunction : bcd_le

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [NUM_CTR-1:0][31:0] pv;
        logic [NUM_CTR-1:0]       cmp_run;
        logic [NUM_CTR-1:0]       pulse_stop;
        logic                     err;
        logic                     rd_valid;
        logic [15:0]              rd_lo;
        logic [15:0]              rd_hi;
    } state_t;

    state_t state;
    state_t next_state;

    logic [NUM_CTR-1:0][NUM_RANGES-1:0] in_range;
    logic [31:0] load_val;
    logic [31:0] pv_min;
    logic [31:0] pv_max;
    logic        ctl_go;
    logic        rd_go;
    logic        ctl_abs;
    logic        rd_abs;

    // range flags follow the live value, so a read never sees a stale copy
    generate
        for (genvar c = 0; c < NUM_CTR; c++)
        begin : g_ctr
            for (genvar r = 0; r < NUM_RANGES; r++)
            begin : g_rng
                assign in_range[c][r] = state.cmp_run[c]
                    && bcd_le(range_lo_i[c][r], state.pv[c])
                    && bcd_le(state.pv[c], range_hi_i[c][r]); // R23
            end
        end
    endgenerate

    // command qualification and limits of the selected counter
    assign ctl_go   = ctl_req_i && ctl_cond_i; // R6
    assign rd_go    = rd_req_i && rd_cond_i; // R6
    assign load_val = {value_source_words_hi_i, value_source_words_lo_i}; // R4
    assign ctl_abs  = (ctl_port_i != PORT_CTR0) && (ctl_port_i <= PORT_CTR2)
                      && ctr12_absolute_i[ctl_port_i[1]];
    assign rd_abs   = (rd_port_i != PORT_CTR0) && (rd_port_i <= PORT_CTR2)
                      && ctr12_absolute_i[rd_port_i[1]];

    always_comb
    begin
        if (ctl_port_i == PORT_CTR0)
        begin
            pv_min = ctr0_updown_i ? PV0_UD_MIN : PV_ZERO; // R8
            pv_max = ctr0_updown_i ? PV0_UD_MAX : PV0_INC_MAX; // R8
        end
        else if (ctr12_ring_i[ctl_port_i[1]])
        begin
            pv_min = PV_ZERO; // R10
            pv_max = PV12_RING_MAX; // R10
        end
        else
        begin
            pv_min = PV12_LIN_MIN; // R10
            pv_max = PV12_LIN_MAX; // R10
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state: control command first, then read command

    always_comb
    begin
        logic [1:0] p;
        logic [1:0] rp;
        logic [15:0] st;
        p          = ctl_port_i;
        rp         = rd_port_i;
        st         = WORD_ZERO;
        next_state = state;
        next_state.pulse_stop = '0;
        next_state.rd_valid   = 1'b0;
        if (ctl_go)
        begin
            next_state.err = 1'b0;
            if (p > PORT_CTR2 || ctl_bad_operand_i
                || (in_interrupt_i && main_busy_i)) // R24 R12 R13
            begin
                next_state.err = 1'b1;
            end
            else
            begin
                case (ctl_code_i) // R1
                    CTL_CMP_START: next_state.cmp_run[p] = 1'b1; // R2
                    CTL_CMP_STOP:  next_state.cmp_run[p] = 1'b0; // R3
                    CTL_PV_LOAD:
                    begin
                        // refuse abs counters, past-end pair, bad or out of range value
                        if (ctl_abs || ctl_past_end_i || !is_bcd(load_val)
                            || !bcd_le(pv_min, load_val) || !bcd_le(load_val, pv_max))
                        begin
                            next_state.err = 1'b1; // R11 R22 R12
                        end
                        else
                        begin
                            next_state.pv[p] = load_val; // R4
                        end
                    end
                    CTL_PULSE_OFF: next_state.pulse_stop[p] = 1'b1; // R5
                    default:       next_state.err = 1'b1; // R24
                endcase
            end
        end
        if (rd_go)
        begin
            next_state.err = ctl_go && next_state.err;
            if (rp > PORT_CTR2 || rd_bad_operand_i || (in_interrupt_i && main_busy_i)
                || (rd_code_i == RD_PV && rd_past_end_i)) // R24 R12 R22
            begin
                next_state.err = 1'b1;
            end
            else
            begin
                // status bits are taken from live inputs, not scan copies
                if (rd_abs)
                begin
                    st[ST_CMP] = state.cmp_run[rp]; // R19
                end
                else
                begin
                    st[ST_CMP]    = state.cmp_run[rp]; // R16
                    st[ST_OVF]    = ovf_seen_i[rp]; // R16 R21
                    st[ST_DECEL]  = decel_spec_i[rp]; // R17
                    st[ST_TOTAL]  = total_spec_i[rp]; // R17
                    st[ST_DONE]   = pulse_done_i[rp]; // R17
                    st[ST_ACTIVE] = pulse_active_i[rp]; // R17 R18
                end
                case (rd_code_i) // R1
                    RD_PV:
                    begin
                        next_state.rd_valid = 1'b1;
                        if (rd_abs)
                        begin
                            next_state.rd_lo = abs_pv_i[rp[1]]; // R15
                            next_state.rd_hi = WORD_ZERO; // R15
                        end
                        else
                        begin
                            next_state.rd_lo = state.pv[rp][15:0]; // R14
                            next_state.rd_hi = state.pv[rp][31:16]; // R14
                        end
                    end
                    RD_STATUS:
                    begin
                        next_state.rd_valid = 1'b1;
                        next_state.rd_lo    = st; // R16
                        next_state.rd_hi    = WORD_ZERO;
                    end
                    RD_RANGES:
                    begin
                        next_state.rd_valid = 1'b1;
                        next_state.rd_lo    = {8'h00, in_range[rp]}; // R20 R21
                        next_state.rd_hi    = WORD_ZERO;
                    end
                    default: next_state.err = 1'b1; // R24
                endcase
            end
        end
    end

    // one register for all state
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign present_value_o = state.pv;
    assign cmp_running_o   = state.cmp_run;
    assign in_range_o      = in_range;
    assign pulse_stop_o    = state.pulse_stop;
    assign error_flag_o    = state.err;
    assign rd_valid_o      = state.rd_valid;
    assign rd_word_lo_o    = state.rd_lo;
    assign rd_word_hi_o    = state.rd_hi;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    sequence s_load_req;
        ctl_go && ctl_code_i == CTL_PV_LOAD && ctl_port_i != PORT_CTR0 && ctl_abs;
    endsequence
    sequence s_start_req;
        ctl_go && ctl_code_i == CTL_CMP_START && ctl_port_i <= PORT_CTR2
            && !ctl_bad_operand_i && !(in_interrupt_i && main_busy_i);
    endsequence

    a_idle_no_effect: assert property (!ctl_go && !rd_go |=> $stable(state.pv)
        && $stable(state.cmp_run) && !rd_valid_o && pulse_stop_o == '0) // R6
        else $error("state changed without an enabled command");
    a_cmp_start: assert property (s_start_req |=> cmp_running_o[$past(ctl_port_i)]) // R2
        else $error("comparison did not start");
    a_cmp_stop: assert property (ctl_go && ctl_code_i == CTL_CMP_STOP && !rd_go
        && !ctl_bad_operand_i && !(in_interrupt_i && main_busy_i) && ctl_port_i <= PORT_CTR2
        |=> !cmp_running_o[$past(ctl_port_i)]) // R3
        else $error("comparison did not stop");
    a_abs_refuse: assert property (s_load_req |=> error_flag_o
        && $stable(present_value_o)) // R11
        else $error("absolute counter value was overwritten");
    a_irq_clash: assert property (ctl_go && in_interrupt_i && main_busy_i |=> error_flag_o) // R13
        else $error("interrupt clash did not raise error");
    a_bad_port: assert property (ctl_go && ctl_port_i > PORT_CTR2 |=> error_flag_o
        && $stable(present_value_o) && $stable(cmp_running_o)) // R24
        else $error("bad port changed state");
    a_pv_read: assert property (rd_go && !ctl_go && rd_code_i == RD_PV && rd_port_i == PORT_CTR0
        && !rd_past_end_i && !rd_bad_operand_i && !(in_interrupt_i && main_busy_i)
        |=> rd_valid_o && {rd_word_hi_o, rd_word_lo_o} == $past(present_value_o[0])) // R14
        else $error("present value read mismatch");
    // only a status read has undefined bits; value reads use all bits, range reads only bits 0..7
    a_status_zero: assert property (rd_valid_o && $past(rd_code_i) == RD_STATUS
        |-> rd_word_lo_o[3:2] == 2'b00 && rd_word_lo_o[15:8] == 8'h00) // R18
        else $error("undefined status bits not zero");
    a_pulse_stop: assert property (ctl_go && ctl_code_i == CTL_PULSE_OFF && ctl_port_i <= PORT_CTR2
        && !ctl_bad_operand_i && !(in_interrupt_i && main_busy_i)
        |=> pulse_stop_o[$past(ctl_port_i)] ##1 (pulse_stop_o == '0 || $past(ctl_go))) // R5
        else $error("pulse stop strobe wrong");
    a_past_end: assert property (rd_go && rd_code_i == RD_PV && rd_past_end_i |=> error_flag_o) // R22
        else $error("past-end read did not raise error");

endmodule : counter_control_and_readout
`default_nettype wire

// File: core/counter_control_pkg.sv
// Purpose : constants shared by the counter control and readout block
// Assumes : present values are signed bcd, eight digits, sign in top digit
// Notes   : codes and limits as the command set defines them
`default_nettype none
package counter_control_pkg;
    localparam logic [1:0]  PORT_CTR0     = 2'h0;
    localparam logic [1:0]  PORT_CTR1     = 2'h1;
    localparam logic [1:0]  PORT_CTR2     = 2'h2;
    localparam logic [1:0]  CTL_CMP_START = 2'h0;
    localparam logic [1:0]  CTL_CMP_STOP  = 2'h1;
    localparam logic [1:0]  CTL_PV_LOAD   = 2'h2;
    localparam logic [1:0]  CTL_PULSE_OFF = 2'h3;
    localparam logic [1:0]  RD_PV         = 2'h0;
    localparam logic [1:0]  RD_STATUS     = 2'h1;
    localparam logic [1:0]  RD_RANGES     = 2'h2;
    // present value limits per counter mode
    localparam logic [31:0] PV0_UD_MIN    = 32'hF003_2767;
    localparam logic [31:0] PV0_UD_MAX    = 32'h0003_2767;
    localparam logic [31:0] PV0_INC_MAX   = 32'h0006_5535;
    localparam logic [31:0] PV12_LIN_MIN  = 32'hF838_8607;
    localparam logic [31:0] PV12_LIN_MAX  = 32'h0838_8607;
    localparam logic [31:0] PV12_RING_MAX = 32'h0006_4999;
    localparam logic [31:0] PV_ZERO       = 32'h0000_0000;
    localparam logic [3:0]  NEG_DIGIT     = 4'hF;
    // status word bit positions
    localparam int unsigned ST_CMP        = 0;
    localparam int unsigned ST_OVF        = 1;
    localparam int unsigned ST_DECEL      = 4;
    localparam int unsigned ST_TOTAL      = 5;
    localparam int unsigned ST_DONE       = 6;
    localparam int unsigned ST_ACTIVE     = 7;
    localparam logic [15:0] WORD_ZERO     = 16'h0000;
endpackage : counter_control_pkg
`default_nettype wire

// File: dv/counter_control_and_readout_tb.sv
// Purpose : self-checking bench for the counter control and readout block
// Assumes : inputs change 1 ns after the rising edge, results read there too
// Notes   : ranges for counter 0 are fixed so only ranges 1 and 8 hold 0050
`default_nettype none
module counter_control_and_readout_tb
    import counter_control_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic                   mclk_i, rst_i, ctl_req, ctl_cond, ctl_past_end, ctl_bad;
    logic                   in_interrupt, main_busy, rd_req, rd_cond, rd_past_end, rd_bad;
    logic [1:0]             ctl_port, ctl_code, rd_port, rd_code;
    logic [15:0]            src_lo, src_hi;
    logic                   ctr0_updown;
    logic [1:0]             ctr12_ring, ctr12_absolute, ctr12_degree;
    logic [1:0][15:0]       abs_pv;
    logic [2:0]             ovf_seen, decel_spec, total_spec, pulse_done, pulse_active;
    logic [2:0][7:0][31:0]  range_lo, range_hi;
    logic [2:0][31:0]       present_value;
    logic [2:0]             cmp_running, pulse_stop;
    logic [2:0][7:0]        in_range;
    logic                   error_flag, rd_valid;
    logic [15:0]            rd_word_lo, rd_word_hi;
    int                     n_mismatch, comparisons;

    counter_control_and_readout u_counter_control_and_readout (
        .mclk_i(mclk_i), .rst_i(rst_i), .ctl_req_i(ctl_req), .ctl_cond_i(ctl_cond),
        .ctl_port_i(ctl_port), .ctl_code_i(ctl_code),
        .value_source_words_lo_i(src_lo), .value_source_words_hi_i(src_hi),
        .ctl_past_end_i(ctl_past_end), .ctl_bad_operand_i(ctl_bad),
        .in_interrupt_i(in_interrupt), .main_busy_i(main_busy),
        .rd_req_i(rd_req), .rd_cond_i(rd_cond), .rd_port_i(rd_port), .rd_code_i(rd_code),
        .rd_past_end_i(rd_past_end), .rd_bad_operand_i(rd_bad),
        .ctr0_updown_i(ctr0_updown), .ctr12_ring_i(ctr12_ring),
        .ctr12_absolute_i(ctr12_absolute), .ctr12_degree_i(ctr12_degree),
        .abs_pv_i(abs_pv), .ovf_seen_i(ovf_seen), .decel_spec_i(decel_spec),
        .total_spec_i(total_spec), .pulse_done_i(pulse_done),
        .pulse_active_i(pulse_active), .range_lo_i(range_lo), .range_hi_i(range_hi),
        .present_value_o(present_value), .cmp_running_o(cmp_running),
        .in_range_o(in_range), .pulse_stop_o(pulse_stop), .error_flag_o(error_flag),
        .rd_valid_o(rd_valid), .rd_word_lo_o(rd_word_lo), .rd_word_hi_o(rd_word_hi)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // clock, verdict and compare helpers
    initial
    begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end

    task automatic close_out;
        if (n_mismatch == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out

    // wide compare; case inequality so an unknown never counts as a match
    task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t value got %h expected %h", $time, got, exp);
        end
    endtask : chk_w

    task automatic chk_b(input logic got, input logic exp);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t flag got %b expected %b", $time, got, exp);
        end
    endtask : chk_b

    // one control command; an idle edge first so the request never drops and
    // rises in one time step; returns one edge later with its effects settled
    task automatic do_ctl(input logic c, input logic [1:0] p, input logic [1:0] k,
                          input logic [31:0] v);
        @(posedge mclk_i);
        #1;
        ctl_req = 1'b1;
        ctl_cond = c;
        ctl_port = p;
        ctl_code = k;
        {src_hi, src_lo} = v;
        @(posedge mclk_i);
        #1;
        ctl_req = 1'b0;
        {src_hi, src_lo} = ~v; // stale source words must not matter after the edge
    endtask : do_ctl

    task automatic do_rd(input logic c, input logic [1:0] p, input logic [1:0] k);
        @(posedge mclk_i);
        #1;
        rd_req = 1'b1;
        rd_cond = c;
        rd_port = p;
        rd_code = k;
        @(posedge mclk_i);
        #1;
        rd_req = 1'b0;
    endtask : do_rd

    // expect a good read with both words
    task automatic exp_rd(input logic [15:0] hi, input logic [15:0] lo);
        chk_b(rd_valid, 1'b1);
        chk_b(error_flag, 1'b0);
        chk_w({rd_word_hi, rd_word_lo}, {hi, lo});
    endtask : exp_rd

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_load_and_limits;
        do_ctl(1'b1, PORT_CTR1, CTL_PV_LOAD, 32'h0000_1234);
        chk_w(present_value[1], 32'h0000_1234);
        chk_b(error_flag, 1'b0);
        do_ctl(1'b0, PORT_CTR1, CTL_PV_LOAD, 32'h0000_5678);
        chk_w(present_value[1], 32'h0000_1234);
        do_ctl(1'b1, PORT_CTR0, CTL_PV_LOAD, 32'h0006_5535);
        chk_w(present_value[0], 32'h0006_5535);
        do_ctl(1'b1, PORT_CTR0, CTL_PV_LOAD, 32'h0006_5536);
        chk_b(error_flag, 1'b1);
        chk_w(present_value[0], 32'h0006_5535);
        ctr0_updown = 1'b1;
        do_ctl(1'b1, PORT_CTR0, CTL_PV_LOAD, 32'hF003_2767);
        chk_w(present_value[0], 32'hF003_2767);
        chk_b(error_flag, 1'b0);
        do_ctl(1'b1, PORT_CTR0, CTL_PV_LOAD, 32'hF003_2768);
        chk_b(error_flag, 1'b1);
        chk_w(present_value[0], 32'hF003_2767);
        do_ctl(1'b1, PORT_CTR1, CTL_PV_LOAD, 32'hF838_8607);
        chk_w(present_value[1], 32'hF838_8607);
        do_ctl(1'b1, PORT_CTR1, CTL_PV_LOAD, 32'h0838_8608);
        chk_b(error_flag, 1'b1);
        do_ctl(1'b1, PORT_CTR2, CTL_PV_LOAD, 32'h0006_4999);
        chk_w(present_value[2], 32'h0006_4999);
        do_ctl(1'b1, PORT_CTR2, CTL_PV_LOAD, 32'h0006_5000);
        chk_b(error_flag, 1'b1);
        chk_w(present_value[2], 32'h0006_4999);
        do_rd(1'b1, PORT_CTR1, RD_PV);
        exp_rd(16'hF838, 16'h8607);
        do_rd(1'b1, PORT_CTR2, RD_PV);
        exp_rd(16'h0006, 16'h4999);
    endtask : t_load_and_limits

    task automatic t_compare;
        do_ctl(1'b1, PORT_CTR0, CTL_PV_LOAD, 32'h0000_0050);
        chk_w(32'(in_range[0]), 32'h0000_0000);
        do_rd(1'b1, PORT_CTR0, RD_PV);
        exp_rd(16'h0000, 16'h0050);
        do_ctl(1'b1, PORT_CTR0, CTL_CMP_START, 32'h0000_0000);
        chk_w(32'(cmp_running), 32'h0000_0001);
        chk_w(32'(in_range[0]), 32'h0000_0081);
        do_rd(1'b1, PORT_CTR0, RD_RANGES);
        exp_rd(16'h0000, 16'h0081);
        do_rd(1'b1, PORT_CTR0, RD_STATUS);
        exp_rd(16'h0000, 16'h0053);
        pulse_active = 3'b001;
        total_spec = 3'b001;
        do_rd(1'b1, PORT_CTR0, RD_STATUS);
        exp_rd(16'h0000, 16'h00F3);
        do_ctl(1'b1, PORT_CTR0, CTL_CMP_STOP, 32'h0000_0000);
        chk_w(32'(cmp_running), 32'h0000_0000);
        chk_w(32'(in_range[0]), 32'h0000_0000);
        do_rd(1'b1, PORT_CTR0, RD_STATUS);
        exp_rd(16'h0000, 16'h00F2);
    endtask : t_compare

    task automatic t_pulse_and_errors;
        do_ctl(1'b1, PORT_CTR2, CTL_PULSE_OFF, 32'h0000_0000);
        chk_w(32'(pulse_stop), 32'h0000_0004);
        @(posedge mclk_i);
        #1;
        chk_w(32'(pulse_stop), 32'h0000_0000);
        do_ctl(1'b1, PORT_CTR2, CTL_PV_LOAD, 32'h0000_0A00);
        chk_b(error_flag, 1'b1);
        chk_w(present_value[2], 32'h0006_4999);
        do_ctl(1'b1, 2'h3, CTL_CMP_START, 32'h0000_0000);
        chk_b(error_flag, 1'b1);
        chk_w(32'(cmp_running), 32'h0000_0000);
        do_ctl(1'b0, PORT_CTR0, CTL_CMP_START, 32'h0000_0000);
        chk_b(error_flag, 1'b1);
        ctl_bad = 1'b1;
        do_ctl(1'b1, PORT_CTR2, CTL_PV_LOAD, 32'h0000_0001);
        ctl_bad = 1'b0;
        chk_b(error_flag, 1'b1);
        chk_w(present_value[2], 32'h0006_4999);
        ctl_past_end = 1'b1;
        do_ctl(1'b1, PORT_CTR2, CTL_PV_LOAD, 32'h0000_0002);
        ctl_past_end = 1'b0;
        chk_b(error_flag, 1'b1);
        chk_w(present_value[2], 32'h0006_4999);
        in_interrupt = 1'b1;
        main_busy = 1'b1;
        do_ctl(1'b1, PORT_CTR1, CTL_CMP_START, 32'h0000_0000);
        chk_b(error_flag, 1'b1);
        chk_w(32'(cmp_running), 32'h0000_0000);
        main_busy = 1'b0;
        do_ctl(1'b1, PORT_CTR0, CTL_PULSE_OFF, 32'h0000_0000);
        chk_b(error_flag, 1'b0);
        in_interrupt = 1'b0;
        do_rd(1'b1, PORT_CTR0, 2'h3);
        chk_b(rd_valid, 1'b0);
        chk_b(error_flag, 1'b1);
        rd_past_end = 1'b1;
        do_rd(1'b1, PORT_CTR0, RD_PV);
        rd_past_end = 1'b0;
        chk_b(rd_valid, 1'b0);
        chk_b(error_flag, 1'b1);
        rd_bad = 1'b1;
        do_rd(1'b1, PORT_CTR0, RD_RANGES);
        rd_bad = 1'b0;
        chk_b(rd_valid, 1'b0);
        do_rd(1'b0, PORT_CTR0, RD_PV);
        chk_b(rd_valid, 1'b0);
    endtask : t_pulse_and_errors

    task automatic t_absolute;
        ctr12_absolute = 2'b01;
        do_ctl(1'b1, PORT_CTR1, CTL_PV_LOAD, 32'h0000_0100);
        chk_b(error_flag, 1'b1);
        chk_w(present_value[1], 32'hF838_8607);
        do_rd(1'b1, PORT_CTR1, RD_PV);
        exp_rd(16'h0000, 16'h4095);
        do_ctl(1'b1, PORT_CTR1, CTL_CMP_START, 32'h0000_0000);
        do_rd(1'b1, PORT_CTR1, RD_STATUS);
        exp_rd(16'h0000, 16'h0001);
        ctr12_absolute = 2'b00;
        do_rd(1'b1, PORT_CTR1, RD_STATUS);
        exp_rd(16'h0000, 16'h0003);
        ctr12_absolute = 2'b10;
        ctr12_degree = 2'b10;
        do_rd(1'b1, PORT_CTR2, RD_PV);
        exp_rd(16'h0000, 16'h0359);
    endtask : t_absolute

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence and watchdog
    initial
    begin
        {rst_i, ctl_req, ctl_cond, ctl_past_end, ctl_bad, in_interrupt} = 6'b10_0000;
        {main_busy, rd_req, rd_cond, rd_past_end, rd_bad, ctr0_updown} = 6'b00_0000;
        {ctl_port, ctl_code, rd_port, rd_code} = 8'h00;
        {src_hi, src_lo} = 32'h0000_0000;
        {ctr12_ring, ctr12_absolute, ctr12_degree} = 6'b10_0000;
        abs_pv = {16'h0359, 16'h4095};
        {ovf_seen, decel_spec, total_spec, pulse_done, pulse_active} = 15'b011_001_000_001_000;
        // ranges 3..7 sit far above the test value, 2 starts just above it, 1 and 8 enclose it
        for (int c = 0; c < 3; c++)
            for (int r = 0; r < 8; r++)
            begin
                range_lo[c][r] = 32'h0000_9000;
                range_hi[c][r] = 32'h0000_9001;
            end
        range_lo[0][0] = 32'h0000_0040;
        range_hi[0][0] = 32'h0000_0060;
        range_lo[0][1] = 32'h0000_0051;
        range_hi[0][1] = 32'h0000_0060;
        range_lo[0][7] = 32'h0000_0050;
        range_hi[0][7] = 32'h0000_0050;
        n_mismatch = 0;
        comparisons = 0;
        repeat (4) @(posedge mclk_i);
        #1;
        rst_i = 1'b0;
        chk_w(present_value[0] | present_value[1] | present_value[2], 32'h0000_0000);
        chk_b(error_flag, 1'b0);
        t_load_and_limits();
        t_compare();
        t_pulse_and_errors();
        t_absolute();
        close_out();
    end

    // the scenarios need well under 200 cycles
    initial
    begin
        #200_000;
        n_mismatch++;
        close_out();
    end
endmodule : counter_control_and_readout_tb
`default_nettype wire
